// File: fepd_power_down_ctrl.v
/*
 * Front-end power-down controller: two pin-selected power profiles,
 * half-duplex fast power switching from the transmit and receive
 * strobes, programmable transmit power-down delay, filter flush, and
 * the bias and converter low-power registers.
 * Assumes a register port on clk_sys_in driven by the serial port
 * logic, and that all pins (strobes, transmit clock, straps) are
 * asynchronous to clk_sys_in, which runs well above the transmit clock.
 */
// Notes on behaviour
// - Select pin low applies low profile.
// - Select pin high applies high profile.
// - Select pin change acts with minimal delay.
// - Low profile resets to all powered on.
// - High profile resets all down except multiplier.
// - Both straps high: high profile all down, osc clock.
// - Profile bits map blocks, set means down.
// - Burst switching power-down within 100 ns.
// - In full duplex, transmit quiet low stops amplifier and filter.
// - Half-duplex register acts only in half-duplex.
// - Default: strobe switches fast blocks, converter on.
// - Strobe fall starts delayed transmit power-down.
// - Five-bit delay field, 0 to 31 clocks.
// - Flush midscale for 33 clocks before power-down.
// - Strobe rise powers transmit up undelayed.
// - Bit 2 picks receive control strobe.
// - Transmit strobe fall/rise powers receive up/down.
// - Receive strobe rise/fall powers receive up/down.
// - Bits 1/0 clear disable fast power-down.
// - Bias register fields, resets to zero.
`timescale 1ns/1ps
`default_nettype none
`include "fepd_map.vh"

module fepd_power_down_ctrl (
  // Clock and reset
  input  wire       clk_sys_in,
  input  wire       sys_rst_in,
  // Register port
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  input  wire       reg_write_in,
  output reg  [7:0] reg_rdata_out,
  // Pins
  input  wire       power_select_pin_in,
  input  wire       transmit_quiet_pin_in,
  input  wire       transmit_enable_strobe_in,
  input  wire       receive_enable_strobe_in,
  input  wire       transmit_clock_in,
  input  wire       duplex_strap_in,
  input  wire       config_strap_in,
  // Power controls to the analog blocks
  output reg  [7:0] block_power_down_out,
  output reg        current_amplifier_power_down_out,
  output reg        interp_filter_disable_out,
  output reg        interp_filter_flush_out,
  output reg        receive_clock_from_osc_out,
  output reg  [7:0] converter_low_power_out,
  output reg  [7:0] receive_bias_adjust_out
);

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  reg [7:0] power_profile_low_reg;
  reg [7:0] power_profile_high_reg;
  reg [7:0] half_duplex_power_savings_reg;
  reg [7:0] converter_low_power_reg;
  reg [7:0] receive_bias_adjust_reg;
  reg       straps_taken_reg;
  reg       full_duplex_reg;
  reg       osc_clock_reg;
  reg [1:0] strap_wait_reg;
  reg       transmit_enable_strobe_dly_reg;
  reg       transmit_clock_dly_reg;
  reg       delay_run_reg;
  reg [4:0] delay_cnt_reg;
  reg       tx_off_reg;
  reg       flush_run_reg;
  reg [5:0] flush_cnt_reg;
  reg       tx_digital_off_reg;

  wire [4:0] delay_field;
  wire       half_duplex;
  wire       transmit_enable_strobe_rise;
  wire       transmit_enable_strobe_fall;
  wire       tx_tick;
  wire       rx_off;
  wire [7:0] profile;
  wire [7:0] fast_down;
  wire [7:0] down_next;
  wire       quiet_active;
  wire       sel_sync;
  wire       quiet_sync;
  wire       transmit_enable_strobe_sync;
  wire       receive_enable_strobe_sync;
  wire       transmit_clock_sync;
  wire       duplex_sync;
  wire       config_sync;

  assign delay_field =
    half_duplex_power_savings_reg[`FEPD_HD_DELAY_HI:`FEPD_HD_DELAY_LO];
  assign half_duplex = ~full_duplex_reg;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Two flops per pin before any logic reads it; each reset level
  // equals the pin's idle level so no false edge follows reset
  fepd_sync2 #(.RST_LEVEL(1'b0)) u_sel_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (power_select_pin_in),
    .sync_out   (sel_sync)
  );
  fepd_sync2 #(.RST_LEVEL(1'b1)) u_quiet_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (transmit_quiet_pin_in),
    .sync_out   (quiet_sync)
  );
  fepd_sync2 #(.RST_LEVEL(1'b0)) u_transmit_enable_strobe_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (transmit_enable_strobe_in),
    .sync_out   (transmit_enable_strobe_sync)
  );
  fepd_sync2 #(.RST_LEVEL(1'b0)) u_receive_enable_strobe_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (receive_enable_strobe_in),
    .sync_out   (receive_enable_strobe_sync)
  );
  fepd_sync2 #(.RST_LEVEL(1'b0)) u_transmit_clock_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (transmit_clock_in),
    .sync_out   (transmit_clock_sync)
  );
  // Straps are static, but are retimed like any other pin
  fepd_sync2 #(.RST_LEVEL(1'b0)) u_duplex_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (duplex_strap_in),
    .sync_out   (duplex_sync)
  );
  fepd_sync2 #(.RST_LEVEL(1'b0)) u_config_sync (
    .clk_sys_in (clk_sys_in),
    .sys_rst_in (sys_rst_in),
    .pin_in     (config_strap_in),
    .sync_out   (config_sync)
  );

  // Third stage feeds the edge detectors only
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      transmit_enable_strobe_dly_reg  <= 1'b0;
      transmit_clock_dly_reg <= 1'b0;
    end else begin
      transmit_enable_strobe_dly_reg  <= transmit_enable_strobe_sync;
      transmit_clock_dly_reg <= transmit_clock_sync;
    end
  end

  // Edges compare the retimed level with its one-cycle copy
  assign transmit_enable_strobe_rise = transmit_enable_strobe_sync & ~transmit_enable_strobe_dly_reg;
  assign transmit_enable_strobe_fall = ~transmit_enable_strobe_sync & transmit_enable_strobe_dly_reg;
  assign tx_tick   = transmit_clock_sync & ~transmit_clock_dly_reg;

  // ------------------------------------------------------------
  // Register file and strap capture
  // ------------------------------------------------------------
  // Straps are taken once both retimed copies have settled after
  // reset release, since an async reset may only load constants.
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      power_profile_low_reg         <= `FEPD_RST_PROFILE_LOW;
      power_profile_high_reg        <= `FEPD_RST_PROFILE_HIGH;
      half_duplex_power_savings_reg <= `FEPD_RST_HALF_DUPLEX;
      converter_low_power_reg       <= `FEPD_RST_CONV_LOWPWR;
      receive_bias_adjust_reg       <= `FEPD_RST_BIAS_ADJUST;
      straps_taken_reg              <= 1'b0;
      strap_wait_reg                <= 2'h0;
      full_duplex_reg               <= 1'b0;
      osc_clock_reg                 <= 1'b0;
    end else if (!straps_taken_reg) begin
      // Retimed strap copies are settled by the third edge
      strap_wait_reg <= strap_wait_reg + 2'h1;
      if (strap_wait_reg == `FEPD_STRAP_WAIT) begin
        straps_taken_reg <= 1'b1;
        full_duplex_reg  <= duplex_sync;
        if (duplex_sync && config_sync) begin
          power_profile_high_reg <= `FEPD_RST_PROFILE_ALL;
          osc_clock_reg          <= 1'b1;
        end
      end
    end else if (reg_write_in) begin
      case (reg_addr_in)
        `FEPD_ADDR_PROFILE_LOW:  power_profile_low_reg <= reg_wdata_in;
        `FEPD_ADDR_PROFILE_HIGH: power_profile_high_reg <= reg_wdata_in;
        `FEPD_ADDR_HALF_DUPLEX: begin
          half_duplex_power_savings_reg <= reg_wdata_in;
        end
        `FEPD_ADDR_CONV_LOWPWR:  converter_low_power_reg <= reg_wdata_in;
        `FEPD_ADDR_BIAS_ADJUST:  receive_bias_adjust_reg <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the address; unmapped reads zero
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= 8'h00;
    end else begin
      case (reg_addr_in)
        `FEPD_ADDR_PROFILE_LOW:  reg_rdata_out <= power_profile_low_reg;
        `FEPD_ADDR_PROFILE_HIGH: reg_rdata_out <= power_profile_high_reg;
        `FEPD_ADDR_HALF_DUPLEX: begin
          reg_rdata_out <= half_duplex_power_savings_reg;
        end
        `FEPD_ADDR_CONV_LOWPWR:  reg_rdata_out <= converter_low_power_reg;
        `FEPD_ADDR_BIAS_ADJUST:  reg_rdata_out <= receive_bias_adjust_reg;
        default:                 reg_rdata_out <= 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Delayed transmit power-down and filter flush
  // ------------------------------------------------------------
  // Counters advance only on transmit clock edges; if that clock
  // stops the flush never finishes and the filter stays powered.
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      delay_run_reg      <= 1'b0;
      delay_cnt_reg      <= 5'h00;
      tx_off_reg         <= 1'b0;
      flush_run_reg      <= 1'b0;
      flush_cnt_reg      <= 6'h00;
      tx_digital_off_reg <= 1'b0;
    end else if (transmit_enable_strobe_rise) begin
      delay_run_reg      <= 1'b0;
      tx_off_reg         <= 1'b0;
      flush_run_reg      <= 1'b0;
      tx_digital_off_reg <= 1'b0;
    end else if (transmit_enable_strobe_fall) begin
      delay_cnt_reg <= 5'h00;
      delay_run_reg <= (delay_field != 5'h00);
      tx_off_reg    <= (delay_field == 5'h00);
      flush_cnt_reg <= 6'h00;
      flush_run_reg <= 1'b1;
    end else if (tx_tick) begin
      if (delay_run_reg) begin
        delay_cnt_reg <= delay_cnt_reg + 5'h01;
        if (delay_cnt_reg + 5'h01 == delay_field) begin
          delay_run_reg <= 1'b0;
          tx_off_reg    <= 1'b1;
        end
      end
      if (flush_run_reg) begin
        flush_cnt_reg <= flush_cnt_reg + 6'h01;
        if (flush_cnt_reg + 6'h01 == `FEPD_FLUSH_CYCLES) begin
          flush_run_reg      <= 1'b0;
          tx_digital_off_reg <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Power-down combination
  // ------------------------------------------------------------
  // Receive source: transmit strobe high or receive strobe low = off
  assign rx_off = half_duplex_power_savings_reg[`FEPD_HD_RX_SRC] ?
                  ~receive_enable_strobe_sync :
                  transmit_enable_strobe_sync;

  assign profile = sel_sync ? power_profile_high_reg
                            : power_profile_low_reg;

  // Fast blocks; converter itself stays up, only the amplifier drops
  assign fast_down[`FEPD_PB_CLK_MULT]    = 1'b0;
  assign fast_down[`FEPD_PB_DAC_AMP]     = 1'b0;
  assign fast_down[`FEPD_PB_TX_DIGITAL]  = half_duplex &
    half_duplex_power_savings_reg[`FEPD_HD_TX_FAST] & tx_digital_off_reg;
  assign fast_down[`FEPD_PB_REFERENCE]   = 1'b0;
  assign fast_down[`FEPD_PB_CONV_CM]     = 1'b0;
  assign fast_down[`FEPD_PB_ADC]         = half_duplex &
    half_duplex_power_savings_reg[`FEPD_HD_RX_FAST] & rx_off;
  assign fast_down[`FEPD_PB_AMP_BIAS]    = 1'b0;
  assign fast_down[`FEPD_PB_RX_GAIN_AMP] = fast_down[`FEPD_PB_ADC];

  assign down_next    = profile | fast_down;
  assign quiet_active = full_duplex_reg & ~quiet_sync;

  // One flop after the synchroniser: no further pipelining
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      block_power_down_out             <= `FEPD_RST_PROFILE_LOW;
      current_amplifier_power_down_out <= 1'b0;
      interp_filter_disable_out        <= 1'b0;
      interp_filter_flush_out          <= 1'b0;
      receive_clock_from_osc_out       <= 1'b0;
      converter_low_power_out          <= `FEPD_RST_CONV_LOWPWR;
      receive_bias_adjust_out          <= `FEPD_RST_BIAS_ADJUST;
    end else begin
      block_power_down_out <= down_next;
      current_amplifier_power_down_out <= down_next[`FEPD_PB_DAC_AMP] |
        quiet_active |
        (half_duplex & tx_off_reg &
         half_duplex_power_savings_reg[`FEPD_HD_TX_FAST]);
      interp_filter_disable_out  <= quiet_active |
                                    down_next[`FEPD_PB_TX_DIGITAL];
      interp_filter_flush_out    <= half_duplex & flush_run_reg;
      receive_clock_from_osc_out <= osc_clock_reg;
      converter_low_power_out    <= converter_low_power_reg;
      receive_bias_adjust_out    <= receive_bias_adjust_reg;
    end
  end

endmodule

// ------------------------------------------------------------
// Two-flop pin synchroniser
// ------------------------------------------------------------
// Reset level should match the pin's idle level, otherwise an
// edge detector behind it sees a false edge after reset.
module fepd_sync2 #(
  parameter [0:0] RST_LEVEL = 1'b0
) (
  // Clock and reset
  input  wire clk_sys_in,
  input  wire sys_rst_in,
  // Asynchronous pin and its retimed copy
  input  wire pin_in,
  output reg  sync_out
);

  reg meta_reg;

  // First flop is read by the second flop only
  always @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      meta_reg <= RST_LEVEL;
      sync_out <= RST_LEVEL;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// File: fepd_map.vh
/*
 * Register offsets, field positions, reset values and counts for the
 * front-end power-down controller.
 * Assumes it is included by bare name from the controller source only.
 */
`ifndef FEPD_MAP_VH
`define FEPD_MAP_VH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define FEPD_ADDR_PROFILE_LOW  8'h01
`define FEPD_ADDR_PROFILE_HIGH 8'h02
`define FEPD_ADDR_HALF_DUPLEX  8'h03
`define FEPD_ADDR_CONV_LOWPWR  8'h07
`define FEPD_ADDR_BIAS_ADJUST  8'h13

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define FEPD_RST_PROFILE_LOW   8'h00
`define FEPD_RST_PROFILE_HIGH  8'h7F
`define FEPD_RST_PROFILE_ALL   8'hFF
`define FEPD_RST_HALF_DUPLEX   8'hFB
`define FEPD_RST_CONV_LOWPWR   8'h00
`define FEPD_RST_BIAS_ADJUST   8'h00

// ------------------------------------------------------------
// Power profile bit positions (set bit = powered down)
// ------------------------------------------------------------
`define FEPD_PB_CLK_MULT       7
`define FEPD_PB_DAC_AMP        6
`define FEPD_PB_TX_DIGITAL     5
`define FEPD_PB_REFERENCE      4
`define FEPD_PB_CONV_CM        3
`define FEPD_PB_ADC            2
`define FEPD_PB_AMP_BIAS       1
`define FEPD_PB_RX_GAIN_AMP    0

// ------------------------------------------------------------
// Half-duplex power savings fields
// ------------------------------------------------------------
`define FEPD_HD_DELAY_HI       7
`define FEPD_HD_DELAY_LO       3
`define FEPD_HD_RX_SRC         2
`define FEPD_HD_TX_FAST        1
`define FEPD_HD_RX_FAST        0

// ------------------------------------------------------------
// Counts in transmit clock cycles
// ------------------------------------------------------------
`define FEPD_FLUSH_CYCLES      6'd33

// ------------------------------------------------------------
// Counts in system clock cycles
// ------------------------------------------------------------
`define FEPD_STRAP_WAIT        2'd2

`endif

// File: fepd_pdc_asserts.sv
/* Port checker for the front-end power-down controller.
   Assumes it is bound to fepd_power_down_ctrl and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module fepd_pdc_asserts (
  // Clock and reset
  input wire logic       clk_sys_in,
  input wire logic       sys_rst_in,
  // Register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_write_in,
  // Pins
  input wire logic       power_select_pin_in,
  input wire logic       transmit_quiet_pin_in,
  input wire logic       transmit_enable_strobe_in,
  input wire logic       receive_enable_strobe_in,
  input wire logic       duplex_strap_in,
  input wire logic       config_strap_in,
  // Power controls
  input wire logic [7:0] block_power_down_out,
  input wire logic       current_amplifier_power_down_out,
  input wire logic       interp_filter_disable_out,
  input wire logic       interp_filter_flush_out,
  input wire logic       receive_clock_from_osc_out
);
  logic [7:0] lo_reg;
  logic [7:0] hi_reg;
  logic [7:0] hd_reg;
  logic [2:0] age_reg;
  wire  [7:0] blk_w = block_power_down_out;
  wire        amp_w = current_amplifier_power_down_out;
  wire        hd_w  = !duplex_strap_in && !power_select_pin_in && !reg_write_in;
  // Shadow registers; third edge after reset takes straps, no write
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lo_reg  <= 8'h00;
      hi_reg  <= 8'h7F;
      hd_reg  <= 8'hFB;
      age_reg <= 3'h0;
    end else begin
      if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
      if (age_reg == 3'h2 && duplex_strap_in && config_strap_in)
        hi_reg <= 8'hFF;
      if (reg_write_in && age_reg > 3'h2 && reg_addr_in == 8'h01)
        lo_reg <= reg_wdata_in;
      if (reg_write_in && age_reg > 3'h2 && reg_addr_in == 8'h02)
        hi_reg <= reg_wdata_in;
      if (reg_write_in && age_reg > 3'h2 && reg_addr_in == 8'h03)
        hd_reg <= reg_wdata_in;
    end
  end
  // ----------------------------------------------------------
  // Properties
  // ----------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_to_high;
    blk_w == lo_reg ##1 blk_w == hi_reg;
  endsequence
  property p_prof_low;
    (duplex_strap_in && !power_select_pin_in && !reg_write_in)[*6]
      |-> blk_w == lo_reg;
  endproperty
  a_prof_low: assert property (p_prof_low)
    else $error("low profile not applied");
  property p_prof_high;
    (duplex_strap_in && power_select_pin_in && !reg_write_in)[*6]
      |-> blk_w == hi_reg;
  endproperty
  a_prof_high: assert property (p_prof_high)
    else $error("high profile not applied");
  property p_sel_lat;
    duplex_strap_in && $rose(power_select_pin_in) |-> ##2 s_to_high;
  endproperty
  a_sel_lat: assert property (p_sel_lat)
    else $error("profile switch latency wrong");
  property p_osc;
    age_reg == 3'h7
      |-> receive_clock_from_osc_out == (duplex_strap_in && config_strap_in);
  endproperty
  a_osc: assert property (p_osc)
    else $error("receive clock source wrong");
  property p_quiet;
    (duplex_strap_in && !transmit_quiet_pin_in)[*5]
      |-> amp_w && interp_filter_disable_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("quiet pin ignored");
  property p_no_flush;
    duplex_strap_in |-> !interp_filter_flush_out;
  endproperty
  a_no_flush: assert property (p_no_flush)
    else $error("flush in full duplex");
  property p_tx_up;
    hd_w && hd_reg[1] && lo_reg[6:5] == 2'h0 &&
      $rose(transmit_enable_strobe_in) |-> ##4 !amp_w && !blk_w[5];
  endproperty
  a_tx_up: assert property (p_tx_up)
    else $error("transmit power-up missing");
  property p_flush;
    hd_w && hd_reg[1] && $fell(transmit_enable_strobe_in)
      |-> ##4 interp_filter_flush_out;
  endproperty
  a_flush: assert property (p_flush)
    else $error("flush not started");
  property p_rx_tx;
    hd_w && hd_reg[0] && !hd_reg[2] && $rose(transmit_enable_strobe_in)
      |-> ##4 blk_w[2] && blk_w[0];
  endproperty
  a_rx_tx: assert property (p_rx_tx)
    else $error("receive not down on transmit");
  property p_rx_rx;
    hd_w && hd_reg[0] && hd_reg[2] && $fell(receive_enable_strobe_in)
      |-> ##4 blk_w[2] && blk_w[0];
  endproperty
  a_rx_rx: assert property (p_rx_rx)
    else $error("receive strobe ignored");
  property p_fast_off;
    (hd_w && lo_reg == 8'h00 && hd_reg[1:0] == 2'h0)[*8]
      |-> (blk_w & 8'h25) == 8'h00 && !amp_w;
  endproperty
  a_fast_off: assert property (p_fast_off)
    else $error("fast power-down not disabled");
endmodule
bind fepd_power_down_ctrl fepd_pdc_asserts u_fepd_pdc_asserts (.*);
`default_nettype wire

// File: fepd_bb_model.sv
/* Baseband controller model: transmit and receive strobes and the
   transmit clock. Assumes tasks are called from the testbench. */
`timescale 1ns/1ps
`default_nettype none
module fepd_bb_model (
  // System clock for pacing
  input  wire logic clk_sys_in,
  // Strobes and clock to the device
  output var logic  transmit_enable_strobe_out,
  output var logic  receive_enable_strobe_out,
  output var logic  transmit_clock_out
);
  // Idle between bursts; clock stands low outside frames
  initial begin
    transmit_enable_strobe_out = 1'b0;
    receive_enable_strobe_out  = 1'b0;
    transmit_clock_out         = 1'b0;
  end
  // Clock phases of three system cycles keep the sampler honest
  task automatic ticks(input int n);
    repeat (n) begin
      repeat (3) @(posedge clk_sys_in);
      #1 transmit_clock_out = 1'b1;
      repeat (3) @(posedge clk_sys_in);
      #1 transmit_clock_out = 1'b0;
    end
  endtask
  // Strobes move together just after an edge
  task automatic strobe(input logic tx, input logic rx);
    @(posedge clk_sys_in);
    #1 transmit_enable_strobe_out = tx;
    receive_enable_strobe_out = rx;
  endtask
endmodule
`default_nettype wire

// File: tb_top.sv
/* Self-checking bench for the front-end power-down controller.
   Assumes the checker is bound and the model drives strobes. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_sys_in, sys_rst_in, reg_write_in, sel, quiet, dup, cfg;
  logic [7:0] reg_addr_in, reg_wdata_in;
  wire  [7:0] rdata, blk, cvt, bias;
  wire        tx_en, rx_en, tclk, amp, fdis, flush, osc;
  int         n_mismatch, cmp_count;
  logic [7:0] ra [6] = '{8'h01, 8'h02, 8'h03, 8'h07, 8'h13, 8'h05};
  logic [7:0] rv [6] = '{8'h00, 8'h7F, 8'hFB, 8'h00, 8'h00, 8'h00};
  fepd_power_down_ctrl u_fepd_power_down_ctrl (.clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_rdata_out(rdata), .power_select_pin_in(sel),
    .transmit_quiet_pin_in(quiet), .transmit_enable_strobe_in(tx_en),
    .receive_enable_strobe_in(rx_en), .transmit_clock_in(tclk),
    .duplex_strap_in(dup), .config_strap_in(cfg),
    .block_power_down_out(blk), .current_amplifier_power_down_out(amp),
    .interp_filter_disable_out(fdis), .interp_filter_flush_out(flush),
    .receive_clock_from_osc_out(osc), .converter_low_power_out(cvt),
    .receive_bias_adjust_out(bias));
  fepd_bb_model u_fepd_bb_model (.clk_sys_in(clk_sys_in),
    .transmit_enable_strobe_out(tx_en), .receive_enable_strobe_out(rx_en),
    .transmit_clock_out(tclk));
  // ----------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_write_in = 1'b1;
    cyc(1);
    reg_write_in = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr_in = a;
    cyc(2);
    chk("rdata", e, rdata);
  endtask
  // Straps are only changed while reset is held
  task automatic rst(input logic d, input logic c);
    dup = d;
    cfg = c;
    sys_rst_in = 1'b1;
    cyc(20);
    sys_rst_in = 1'b0;
    cyc(2);
  endtask
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Clock and watchdog
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    repeat (60000) @(posedge clk_sys_in);
    n_mismatch++;
    stop_test();
  end
  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {reg_write_in, sel, reg_addr_in, reg_wdata_in} = 18'h0;
    quiet = 1'b1;
    rst(1'b0, 1'b0);
    foreach (ra[i]) rd(ra[i], rv[i]);
    wr(8'h13, 8'hA5);
    wr(8'h07, 8'h5A);
    rd(8'h13, 8'hA5);
    chk("bias", 8'hA5, bias);
    chk("conv", 8'h5A, cvt);
    // Default half-duplex burst with full 31-clock delay and flush
    u_fepd_bb_model.strobe(1'b1, 1'b0);
    cyc(6);
    chk("blk", 8'h05, blk);
    u_fepd_bb_model.strobe(1'b0, 1'b0);
    cyc(6);
    chk("flush", 8'h01, {7'h0, flush});
    u_fepd_bb_model.ticks(30);
    cyc(4);
    chk("amp", 8'h00, {7'h0, amp});
    u_fepd_bb_model.ticks(1);
    cyc(4);
    chk("amp", 8'h01, {7'h0, amp});
    u_fepd_bb_model.ticks(2);
    cyc(4);
    chk("blk", 8'h20, blk);
    chk("fdis", 8'h01, {7'h0, fdis});
    // Zero delay, receive strobe as source
    wr(8'h03, 8'h07);
    u_fepd_bb_model.strobe(1'b1, 1'b1);
    cyc(6);
    chk("blk", 8'h00, blk);
    u_fepd_bb_model.strobe(1'b0, 1'b0);
    cyc(6);
    chk("amp", 8'h01, {7'h0, amp});
    chk("blk", 8'h05, blk);
    // Fast power-down switched off
    u_fepd_bb_model.strobe(1'b1, 1'b1);
    wr(8'h03, 8'h04);
    u_fepd_bb_model.strobe(1'b1, 1'b0);
    cyc(6);
    chk("blk", 8'h00, blk);
    u_fepd_bb_model.strobe(1'b0, 1'b0);
    cyc(6);
    chk("amp", 8'h00, {7'h0, amp});
    // Full duplex with both straps high
    rst(1'b1, 1'b1);
    rd(8'h02, 8'hFF);
    chk("osc", 8'h01, {7'h0, osc});
    wr(8'h01, 8'h60);
    wr(8'h02, 8'h05);
    cyc(6);
    sel = 1'b1;
    cyc(4);
    chk("blk", 8'h05, blk);
    cyc(2);
    chk("blk", 8'h05, blk);
    sel = 1'b0;
    cyc(4);
    chk("blk", 8'h60, blk);
    quiet = 1'b0;
    cyc(6);
    chk("quiet", 8'h03, {6'h0, amp, fdis});
    quiet = 1'b1;
    u_fepd_bb_model.strobe(1'b1, 1'b0);
    u_fepd_bb_model.strobe(1'b0, 1'b0);
    cyc(6);
    chk("blk", 8'h60, blk);
    chk("flush", 8'h00, {7'h0, flush});
    stop_test();
  end
endmodule
`default_nettype wire
